/* File: ech_pkg.sv */
// Constants, field layout and carrier types for the config header tail
package ech_pkg;
   // Dword-aligned byte offsets of the two words that this block answers
   localparam logic [11:0] ECH_INTR_DW_OFS = 12'h03c;
   localparam logic [11:0] ECH_CAP_DW_OFS  = 12'h040;
   localparam int          ECH_IDX_W       = 10;
   localparam logic [ECH_IDX_W-1:0] ECH_INTR_IDX = ECH_INTR_DW_OFS[11:2];
   localparam logic [ECH_IDX_W-1:0] ECH_CAP_IDX  = ECH_CAP_DW_OFS[11:2];
   // Byte offsets of the single-byte registers
   localparam logic [11:0] ECH_PIN_OFS     = 12'h03d;
   localparam logic [11:0] ECH_MIN_GNT_OFS = 12'h03e;
   localparam logic [11:0] ECH_MAX_LAT_OFS = 12'h03f;
   // Byte lanes
   localparam int ECH_PIN_LANE  = int'(ECH_PIN_OFS[1:0]);
   localparam int ECH_NXT_LANE  = 1;
   localparam int ECH_VER_LANE  = 2;
   // Field positions in the capability header and in the interrupt pin dword
   localparam int ECH_ID_LSB    = 0;
   localparam int ECH_NXT_LSB   = 8;
   localparam int ECH_VER_LSB   = 16;
   localparam int ECH_VER_W     = 4;
   localparam int ECH_TYPE_LSB  = 20;
   localparam int ECH_TYPE_W    = 4;
   localparam int ECH_SLOT_BIT  = 24;
   localparam int ECH_IMN_LSB   = 25;
   localparam int ECH_IMN_W     = 5;
   localparam int ECH_RSV_LSB   = 30;
   localparam int ECH_RSV_W     = 2;
   localparam int ECH_PIN_LSB   = 8;
   localparam int ECH_GNT_LSB   = 16;
   localparam int ECH_LAT_LSB   = 24;
   // Fixed and reset values
   localparam logic [7:0] ECH_PIN_RST   = 8'h00;
   localparam logic [7:0] ECH_INTX_NONE = 8'h00;
   localparam logic [7:0] ECH_INTX_A    = 8'h01;
   localparam logic [7:0] ECH_INTX_D    = 8'h04;
   localparam logic [7:0] ECH_MIN_GNT   = 8'h00;
   localparam logic [7:0] ECH_MAX_LAT   = 8'h00;
   localparam logic [7:0] ECH_CAP_ID    = 8'h10;
   localparam logic [7:0] ECH_NXT_RST   = 8'h00;
   localparam logic [3:0] ECH_VER_RST   = 4'h2;
   localparam logic [3:0] ECH_TYPE_EP   = 4'h0;
   localparam logic [0:0] ECH_SLOT_NONE = 1'h0;
   localparam logic [4:0] ECH_IMN_ZERO  = 5'h00;
   localparam logic [1:0] ECH_RSV_ZERO  = 2'h0;
   localparam int         ECH_MODE_W    = 2;

   // Configuration request, taken in the cycle that valid is high
   typedef struct packed {
      logic                 wr;
      logic [ECH_IDX_W-1:0] idx;
      logic [3:0]           be;
      logic [31:0]          wdata;
   } ech_req_t;

   // Answer, one cycle after the request
   typedef struct packed {
      logic        ack;
      logic        hit;
      logic [31:0] rdata;
   } ech_rsp_t;

   // Legacy interrupt message request
   typedef struct packed {
      logic       valid;
      logic       assert_msg;
      logic [1:0] lane;
   } ech_intx_t;

   // Interrupt message tracker states
   typedef enum logic [0:0] {
      ECH_INTX_IDLE   = 1'b0,
      ECH_INTX_ACTIVE = 1'b1
   } ech_intx_st_t;
endpackage

/* File: ech_sync2.sv */
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module ech_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // First stage is read only by the second stage
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* File: ech_lock_field.sv */
// Lockable software field, optionally following a hardware default
`timescale 1ns/1ps
`default_nettype none
module ech_lock_field #(
   parameter int           W     = 8,
   parameter logic [W-1:0] RST   = '0,
   parameter bit           TRACK = 1'b0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         wr_en,
   input  wire logic         locked,
   input  wire logic [W-1:0] wdata,
   input  wire logic [W-1:0] dflt,
   output var  logic [W-1:0] q,
   output var  logic         written
);
   logic take;

   // Writes land only while the lock is open
   assign take = wr_en && !locked;

   // Field value: a software value sticks, else the default is followed
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= RST;
      end
      else if (take)
      begin
         q <= wdata;
      end
      else if (TRACK && !written)
      begin
         q <= dflt;
      end
   end

   // Remembers that software has owned the field since reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         written <= 1'b0;
      end
      else if (take)
      begin
         written <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: ech_cfg_tail.sv */
// Endpoint config header tail: interrupt pin, grant/latency, cap header
//
// Operation
// - Selector values one to four pick legacy messages INTA to INTD.
// - A selector of zero means no legacy interrupt message is ever sent.
// - The eight-bit selector resets to zero and is writable unless locked.
// - The minimum grant and maximum latency bytes are read-only zero.
// - The capability header's lowest byte reads the express capability code.
// - The next link byte follows a mode default until software writes it.
// - The four-bit revision field resets to two and is lockable writable.
// - The four-bit port type field is read-only zero, marking an endpoint.
// - The five-bit interrupt message index is read-only zero.
`timescale 1ns/1ps
`default_nettype none
module ech_cfg_tail #(
   parameter logic [7:0] NXT_MODE0 = 8'h00,
   parameter logic [7:0] NXT_MODE1 = 8'h50,
   parameter logic [7:0] NXT_MODE2 = 8'h70,
   parameter logic [7:0] NXT_MODE3 = 8'h00
) (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic                         cfg_req_valid,
   input  wire ech_pkg::ech_req_t            cfg_req,
   output var  ech_pkg::ech_rsp_t            cfg_rsp_r,
   input  wire logic                         cfg_lock_pin,
   input  wire logic [ech_pkg::ECH_MODE_W-1:0] port_mode_pin,
   input  wire logic                         intx_level,
   output var  ech_pkg::ech_intx_t           intx_msg_r,
   output var  logic                         intx_enable_r
);
   logic                           lock_s;
   logic [ech_pkg::ECH_MODE_W-1:0] mode_s;
   logic [7:0]                     pin_sel;
   logic [7:0]                     nxt_link;
   logic [7:0]                     nxt_dflt;
   logic                           nxt_written;
   logic [3:0]                     cap_rev;
   logic                           pin_wr;
   logic                           nxt_wr;
   logic                           rev_wr;
   logic                           sel_valid;
   logic [1:0]                     sel_lane;
   logic                           level_d_r;
   logic [1:0]                     act_lane_r;
   logic [ech_pkg::ECH_IDX_W-1:0]  rsp_idx_r;
   ech_pkg::ech_intx_st_t          intx_st_r;
   ech_pkg::ech_intx_st_t          intx_st_nxt;

   // Write strobe for one byte lane of one dword
   function automatic logic lane_wr(input logic v,
                                    input ech_pkg::ech_req_t r,
                                    input logic [ech_pkg::ECH_IDX_W-1:0] i,
                                    input int lane);
      lane_wr = v && r.wr && (r.idx == i) && r.be[lane];
   endfunction

   // Mode-dependent default of the next capability link
   function automatic logic [7:0] mode_link(
      input logic [ech_pkg::ECH_MODE_W-1:0] m);
      unique case (m)
         2'h0:    mode_link = NXT_MODE0;
         2'h1:    mode_link = NXT_MODE1;
         2'h2:    mode_link = NXT_MODE2;
         2'h3:    mode_link = NXT_MODE3;
      endcase
   endfunction

   // Pin inputs cross into the clock domain
   ech_sync2 #(
      .W (1)
   ) u_lock_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (cfg_lock_pin),
      .q     (lock_s)
   );

   ech_sync2 #(
      .W (ech_pkg::ECH_MODE_W)
   ) u_mode_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (port_mode_pin),
      .q     (mode_s)
   );

   // Byte-lane write strobes; read-only lanes have none
   assign pin_wr = lane_wr(cfg_req_valid, cfg_req, ech_pkg::ECH_INTR_IDX,
                           ech_pkg::ECH_PIN_LANE);
   assign nxt_wr = lane_wr(cfg_req_valid, cfg_req, ech_pkg::ECH_CAP_IDX,
                           ech_pkg::ECH_NXT_LANE);
   assign rev_wr = lane_wr(cfg_req_valid, cfg_req, ech_pkg::ECH_CAP_IDX,
                           ech_pkg::ECH_VER_LANE);
   assign nxt_dflt = mode_link(mode_s);

   // Interrupt pin selector, lockable
   ech_lock_field #(
      .W     (8),
      .RST   (ech_pkg::ECH_PIN_RST),
      .TRACK (1'b0)
   ) u_pin_sel (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (pin_wr),
      .locked  (lock_s),
      .wdata   (cfg_req.wdata[ech_pkg::ECH_PIN_LSB +: 8]),
      .dflt    (ech_pkg::ECH_PIN_RST),
      .q       (pin_sel),
      .written ()
   );

   // Next capability link, follows the mode until written
   ech_lock_field #(
      .W     (8),
      .RST   (ech_pkg::ECH_NXT_RST),
      .TRACK (1'b1)
   ) u_nxt_link (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (nxt_wr),
      .locked  (lock_s),
      .wdata   (cfg_req.wdata[ech_pkg::ECH_NXT_LSB +: 8]),
      .dflt    (nxt_dflt),
      .q       (nxt_link),
      .written (nxt_written)
   );

   // Capability revision, lockable; port type nibble of the lane is dropped
   ech_lock_field #(
      .W     (ech_pkg::ECH_VER_W),
      .RST   (ech_pkg::ECH_VER_RST),
      .TRACK (1'b0)
   ) u_cap_rev (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (rev_wr),
      .locked  (lock_s),
      .wdata   (cfg_req.wdata[ech_pkg::ECH_VER_LSB +: ech_pkg::ECH_VER_W]),
      .dflt    (ech_pkg::ECH_VER_RST),
      .q       (cap_rev),
      .written ()
   );

   // Selector decode: only one to four name a message lane
   assign sel_valid = (pin_sel >= ech_pkg::ECH_INTX_A) &&
                      (pin_sel <= ech_pkg::ECH_INTX_D);
   assign sel_lane  = 2'(pin_sel - ech_pkg::ECH_INTX_A);

   // Answer to each request, one cycle later
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_rsp_r <= '0;
         rsp_idx_r <= '0;
      end
      else
      begin
         cfg_rsp_r.ack   <= cfg_req_valid;
         cfg_rsp_r.hit   <= cfg_req_valid &&
                            (cfg_req.idx == ech_pkg::ECH_INTR_IDX ||
                             cfg_req.idx == ech_pkg::ECH_CAP_IDX);
         cfg_rsp_r.rdata <= '0;
         rsp_idx_r       <= cfg_req.idx;
         if (cfg_req_valid && !cfg_req.wr &&
             cfg_req.idx == ech_pkg::ECH_INTR_IDX)
         begin
            cfg_rsp_r.rdata[ech_pkg::ECH_PIN_LSB +: 8] <= pin_sel;
            cfg_rsp_r.rdata[ech_pkg::ECH_GNT_LSB +: 8] <=
               ech_pkg::ECH_MIN_GNT;
            cfg_rsp_r.rdata[ech_pkg::ECH_LAT_LSB +: 8] <=
               ech_pkg::ECH_MAX_LAT;
         end
         else if (cfg_req_valid && !cfg_req.wr &&
                  cfg_req.idx == ech_pkg::ECH_CAP_IDX)
         begin
            cfg_rsp_r.rdata <= {ech_pkg::ECH_RSV_ZERO,
                                ech_pkg::ECH_IMN_ZERO,
                                ech_pkg::ECH_SLOT_NONE,
                                ech_pkg::ECH_TYPE_EP,
                                cap_rev,
                                nxt_link,
                                ech_pkg::ECH_CAP_ID};
         end
      end
   end

   // Interrupt enable view and level history
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         intx_enable_r <= 1'b0;
         level_d_r     <= 1'b0;
      end
      else
      begin
         intx_enable_r <= sel_valid;
         level_d_r     <= intx_level;
      end
   end

   // Message tracker next state
   always_comb
   begin
      intx_st_nxt = intx_st_r;
      unique case (intx_st_r)
         ech_pkg::ECH_INTX_IDLE:
            if (sel_valid && intx_level && !level_d_r)
               intx_st_nxt = ech_pkg::ECH_INTX_ACTIVE;
         ech_pkg::ECH_INTX_ACTIVE:
            if (!sel_valid || !intx_level)
               intx_st_nxt = ech_pkg::ECH_INTX_IDLE;
      endcase
   end

   // Assert on a rising level, deassert on the lane that was asserted
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         intx_st_r  <= ech_pkg::ECH_INTX_IDLE;
         act_lane_r <= 2'h0;
         intx_msg_r <= '0;
      end
      else
      begin
         intx_st_r        <= intx_st_nxt;
         intx_msg_r.valid <= 1'b0;
         if (intx_st_r == ech_pkg::ECH_INTX_IDLE &&
             intx_st_nxt == ech_pkg::ECH_INTX_ACTIVE)
         begin
            act_lane_r            <= sel_lane;
            intx_msg_r.valid      <= 1'b1;
            intx_msg_r.assert_msg <= 1'b1;
            intx_msg_r.lane       <= sel_lane;
         end
         else if (intx_st_r == ech_pkg::ECH_INTX_ACTIVE &&
                  sel_valid && !intx_level)
         begin
            intx_msg_r.valid      <= 1'b1;
            intx_msg_r.assert_msg <= 1'b0;
            intx_msg_r.lane       <= act_lane_r;
         end
      end
   end

   // Checks
   a_intx_lane_map: assert property (
      @(posedge clk) disable iff (!rst_n)
      intx_msg_r.valid && intx_msg_r.assert_msg |->
         $past(sel_valid) &&
         intx_msg_r.lane == 2'($past(pin_sel) - 8'h01))
      else $error("message lane does not match selector");

   a_intx_none_sent: assert property (
      @(posedge clk) disable iff (!rst_n)
      pin_sel == 8'h00 |=> !intx_msg_r.valid && !intx_enable_r)
      else $error("message sent with selector zero");

   a_pin_sel_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      pin_wr |=> pin_sel == ($past(lock_s) ? $past(pin_sel) :
                             $past(cfg_req.wdata[15:8])))
      else $error("selector write not honoured or lock ignored");

   a_grant_lat_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      cfg_rsp_r.ack && rsp_idx_r == 10'h00f |-> cfg_rsp_r.rdata[31:16] == 0)
      else $error("grant or latency byte not zero");

   a_cap_id_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      cfg_req_valid && !cfg_req.wr && cfg_req.idx == 10'h010 |=>
         cfg_rsp_r.ack && cfg_rsp_r.rdata[7:0] == 8'h10)
      else $error("capability code wrong");

   a_next_link_keep: assert property (
      @(posedge clk) disable iff (!rst_n)
      !nxt_wr |=> nxt_link == ($past(nxt_written) ? $past(nxt_link) :
                                 $past(nxt_dflt)))
      else $error("next link neither kept nor following mode");

   a_rev_lock: assert property (
      @(posedge clk) disable iff (!rst_n)
      (lock_s || !rev_wr) ##1 !rev_wr |-> $stable(cap_rev))
      else $error("revision changed without an open write");

   a_type_imn_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      cfg_rsp_r.ack && rsp_idx_r == 10'h010 && !$past(cfg_req.wr) |->
         cfg_rsp_r.rdata[29:20] == 10'h000 && cfg_rsp_r.rdata[19:16] == cap_rev)
      else $error("port type or message index not zero");

   a_ro_bits_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      cfg_rsp_r.ack |-> cfg_rsp_r.rdata[31:30] == 2'h0 &&
         (rsp_idx_r == 10'h00f || cfg_rsp_r.rdata[24] == 1'b0))
      else $error("read-only bits not zero");
endmodule
`default_nettype wire

/* File: ech_host_model.sv */
// Host model issuing configuration reads and writes to the header tail
`timescale 1ns/1ps
`default_nettype none
module ech_host_model (
   input  wire logic              clk,
   output var  logic              cfg_req_valid,
   output var  ech_pkg::ech_req_t cfg_req,
   input  wire ech_pkg::ech_rsp_t cfg_rsp_r
);
   // Idle at time zero
   initial
   begin
      cfg_req_valid = 1'b0;
      cfg_req       = '0;
   end

   // One request: strobe for one cycle, answer taken one edge later
   task automatic access(input  logic                          wr,
                         input  logic [ech_pkg::ECH_IDX_W-1:0] idx,
                         input  logic [3:0]                    be,
                         input  logic [31:0]                   wdata,
                         output ech_pkg::ech_rsp_t             rsp);
      ech_pkg::ech_req_t r;
      r = '{wr: wr, idx: idx, be: be, wdata: wdata};
      @(posedge clk);
      cfg_req_valid <= 1'b1;
      cfg_req       <= r;
      @(posedge clk);
      cfg_req_valid <= 1'b0;
      cfg_req       <= ech_pkg::ech_req_t'(~r); // Released lines show junk
      @(posedge clk);
      rsp = cfg_rsp_r;
   endtask
endmodule
`default_nettype wire

/* File: test_endpoint_config_header_tail.sv */
// Self-checking testbench for the config header tail
`timescale 1ns/1ps
`default_nettype none
module test_endpoint_config_header_tail;
   localparam logic [7:0] NXT1  = 8'h50;
   localparam logic [7:0] NXT2  = 8'h70;
   localparam logic [7:0] NXT3  = 8'h60;
   localparam logic [9:0] IPIN  = ech_pkg::ECH_INTR_IDX;
   localparam logic [9:0] ICAP  = ech_pkg::ECH_CAP_IDX;
   localparam int         LIMIT = 3000;

   logic               clk;
   logic               rst_n;
   logic               cfg_req_valid;
   ech_pkg::ech_req_t  cfg_req;
   ech_pkg::ech_rsp_t  cfg_rsp_r;
   logic               cfg_lock_pin;
   logic [1:0]         port_mode_pin;
   logic               intx_level;
   ech_pkg::ech_intx_t intx_msg_r;
   logic               intx_enable_r;
   ech_pkg::ech_rsp_t  rsp;
   int                 n_fail;
   int                 comparisons;
   int                 cycles = 0;
   int                 s;

   ech_cfg_tail #(
      .NXT_MODE0 (8'h00),
      .NXT_MODE1 (NXT1),
      .NXT_MODE2 (NXT2),
      .NXT_MODE3 (NXT3)
   ) dut (
      .clk           (clk),
      .rst_n         (rst_n),
      .cfg_req_valid (cfg_req_valid),
      .cfg_req       (cfg_req),
      .cfg_rsp_r     (cfg_rsp_r),
      .cfg_lock_pin  (cfg_lock_pin),
      .port_mode_pin (port_mode_pin),
      .intx_level    (intx_level),
      .intx_msg_r    (intx_msg_r),
      .intx_enable_r (intx_enable_r)
   );

   ech_host_model host (
      .clk           (clk),
      .cfg_req_valid (cfg_req_valid),
      .cfg_req       (cfg_req),
      .cfg_rsp_r     (cfg_rsp_r)
   );

   // Clock of 40 ns period
   always #20 clk = ~clk;

   // Hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         n_fail++;
         summarize();
      end
   end

   // Expected capability header word
   function automatic logic [31:0] cap_word(input logic [7:0] nxt,
                                            input logic [3:0] capability_revision_field);
      return {ech_pkg::ECH_RSV_ZERO, ech_pkg::ECH_IMN_ZERO,
              ech_pkg::ECH_SLOT_NONE, ech_pkg::ECH_TYPE_EP, capability_revision_field, nxt,
              ech_pkg::ECH_CAP_ID};
   endfunction

   // Expected word holding selector, grant and latency bytes
   function automatic logic [31:0] pin_word(input logic [7:0] sel);
      return {ech_pkg::ECH_MAX_LAT, ech_pkg::ECH_MIN_GNT, sel, 8'h00};
   endfunction

   // Compare and count
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Read one dword and compare ack, hit and data
   task automatic rd(input logic [9:0] idx, input logic [31:0] exp,
                     input logic hit);
      host.access(1'b0, idx, 4'hf, 32'h0000_0000, rsp);
      check({rsp.ack, rsp.hit, rsp.rdata}, {1'b1, hit, exp});
   endtask

   // Write one dword; writes answer with zero data
   task automatic wr(input logic [9:0] idx, input logic [3:0] be,
                     input logic [31:0] data);
      host.access(1'b1, idx, be, data, rsp);
      check(34'({rsp.ack, rsp.rdata}), {2'b01, 32'h0000_0000});
   endtask

   // Wait a bounded time for a message and check its kind and lane
   task automatic wait_msg(input logic asrt, input logic [1:0] lane);
      int i;
      for (i = 0; i < 10; i++)
      begin
         @(posedge clk);
         if (intx_msg_r.valid === 1'b1)
            break;
      end
      check(34'({intx_msg_r.valid, intx_msg_r.assert_msg, intx_msg_r.lane}),
            34'({1'b1, asrt, lane}));
   endtask

   // Verdict and end of run
   task automatic summarize();
      if (n_fail == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      clk           = 1'b0;
      rst_n         = 1'b0;
      cfg_lock_pin  = 1'b0;
      port_mode_pin = 2'h1;
      intx_level    = 1'b0;
      n_fail        = 0;
      comparisons   = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(IPIN, pin_word(8'h00), 1'b1);
      rd(ICAP, cap_word(NXT1, 4'h2), 1'b1);
      port_mode_pin <= 2'h2;
      repeat (4) @(posedge clk);
      rd(ICAP, cap_word(NXT2, 4'h2), 1'b1);
      wr(IPIN, 4'hf, 32'hffff_ffff);
      rd(IPIN, pin_word(8'hff), 1'b1);
      check(34'(intx_enable_r), 34'h0);
      wr(ICAP, 4'hf, 32'hffff_ffff);
      rd(ICAP, cap_word(8'hff, 4'hf), 1'b1);
      port_mode_pin <= 2'h1;
      repeat (4) @(posedge clk);
      rd(ICAP, cap_word(8'hff, 4'hf), 1'b1);
      wr(ICAP, 4'h4, 32'h0003_0000);
      rd(ICAP, cap_word(8'hff, 4'h3), 1'b1);
      // Locked fields refuse writes
      cfg_lock_pin <= 1'b1;
      repeat (4) @(posedge clk);
      wr(IPIN, 4'h2, 32'h0000_0300);
      wr(ICAP, 4'h6, 32'h0009_1200);
      rd(IPIN, pin_word(8'hff), 1'b1);
      rd(ICAP, cap_word(8'hff, 4'h3), 1'b1);
      cfg_lock_pin <= 1'b0;
      repeat (4) @(posedge clk);
      // Address outside the block
      wr(10'h011, 4'hf, 32'hffff_ffff);
      rd(10'h011, 32'h0000_0000, 1'b0);
      // Each selector value from one to four picks its own lane
      for (s = 1; s <= 4; s++)
      begin
         wr(IPIN, 4'h2, {16'h0000, 8'(s), 8'h00});
         @(posedge clk);
         check(34'(intx_enable_r), 34'h1);
         intx_level <= 1'b1;
         wait_msg(1'b1, 2'(s - 1));
         intx_level <= 1'b0;
         wait_msg(1'b0, 2'(s - 1));
      end
      // Selector zero sends nothing
      wr(IPIN, 4'h2, 32'h0000_0000);
      @(posedge clk);
      check(34'(intx_enable_r), 34'h0);
      intx_level <= 1'b1;
      repeat (6)
      begin
         @(posedge clk);
         check(34'(intx_msg_r.valid), 34'h0);
      end
      intx_level <= 1'b0;
      wr(IPIN, 4'h2, 32'h0000_0200);
      wr(ICAP, 4'h6, 32'h0005_3300);
      // Second reset in mid-run restores defaults
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(IPIN, pin_word(8'h00), 1'b1);
      rd(ICAP, cap_word(NXT1, 4'h2), 1'b1);
      // Remaining operating modes pick their own link defaults
      port_mode_pin <= 2'h3;
      repeat (4) @(posedge clk);
      rd(ICAP, cap_word(NXT3, 4'h2), 1'b1);
      port_mode_pin <= 2'h0;
      repeat (4) @(posedge clk);
      rd(ICAP, cap_word(8'h00, 4'h2), 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
